// [rtl/rxgt_top.sv]
// Receiver gain control and timing recovery top with register port
// Behaviour
// - Attenuation moves in 6 dB steps, never beyond 48 dB.
// - Peak amplitude after decimation is compared with low and high threshold.
// - Above high threshold, attenuation rises one step at a time; field 0..8.
// - Per-step select bits choose one of two low thresholds.
// - Attenuation drops only if amplitude stayed under low threshold all interval.
// - Measure interval is 12 cycles times two to the measure field.
// - After a change, wait 12 cycles times hold field before evaluating.
// - Above high, update each hold; below low, each measure plus hold.
// - Loop runs only when enabled; freeze-on-sync holds attenuation after sync.
// - Order bit picks first-order delay loop or second-order loop.
// - Post-filter length bit lengthens demodulator post-filter when set.
// - Timing recovery starts only above the signal level threshold.
// - First-order mode only corrects delay of the local bit timing.
// - Proportional gain 0..7; smaller gives faster convergence.
// - Second-order mode corrects frequency and phase to hold lock.
// - Fast gain pair before sync, slow gain pair after.
// - Channel filter word: mantissa 0..8, exponent 0..9.
// - Intermediate frequency offset field drives the IF setting.
`timescale 1ns/1ps
module rxgt_top (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  input wire logic [3:0] i_peak_amp,
  input wire logic [7:0] i_rssi,
  input wire logic i_sync_det,
  input wire logic i_rx_start,
  input wire logic [7:0] i_phase_err,
  input wire logic i_phase_valid,
  output logic [3:0] o_atten_step,
  output logic o_timing_order,
  output logic o_postfilt_long,
  output logic [15:0] o_timing_adj,
  output logic [15:0] o_timing_freq,
  output logic o_timing_active,
  output logic [3:0] o_channel_filter_word_mant,
  output logic [3:0] o_channel_filter_word_exp,
  output logic [7:0] o_if_offset
);
  logic [3:0] high_th_q, high_th_d;
  logic [3:0] low_th0_q, low_th0_d;
  logic [3:0] low_th1_q, low_th1_d;
  logic [7:0] low_sel_q, low_sel_d;
  logic [3:0] meas_q, meas_d;
  logic [5:0] hold_q, hold_d;
  logic [1:0] gctrl_q, gctrl_d;
  logic [1:0] tcfg_q, tcfg_d;
  logic [7:0] pgain_q, pgain_d;
  logic [7:0] igain_q, igain_d;
  logic [7:0] sig_th_q, sig_th_d;
  logic [3:0] mant_q, mant_d;
  logic [3:0] exp_q, exp_d;
  logic [7:0] if_ofs_q, if_ofs_d;
  logic [7:0] rdata_q, rdata_d;
  logic sync_q, sync_d;
  rxgt_pkg::rxgt_gain_state_e st_q, st_d;
  logic [3:0] step_q, step_d;
  logic [18:0] cnt_q, cnt_d;
  logic all_low_q, all_low_d;
  logic [18:0] meas_len;
  logic [18:0] hold_len;
  logic [18:0] meas_load;
  logic [18:0] hold_load;
  logic gain_en;
  logic frozen;

  rxgt_link_if lk ();

  rxgt_gain_eval u_eval (
    .lk(lk.eval)
  );

  rxgt_timing_loop u_timing (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .lk(lk.timing)
  );

  assign lk.amp = i_peak_amp;
  assign lk.high_th = high_th_q;
  assign lk.low_th0 = low_th0_q;
  assign lk.low_th1 = low_th1_q;
  assign lk.low_sel = low_sel_q;
  assign lk.step = step_q;
  assign lk.order = tcfg_q[rxgt_pkg::CFG_ORDER_BIT];
  assign lk.kp_fast = pgain_q[2:0];
  assign lk.kp_slow = pgain_q[rxgt_pkg::PGAIN_SLOW_LSB +: 3];
  assign lk.ki_fast = igain_q[3:0];
  assign lk.ki_slow = igain_q[rxgt_pkg::IGAIN_SLOW_LSB +: 4];
  assign lk.sig_th = sig_th_q;
  assign lk.rssi = i_rssi;
  assign lk.sync_seen = sync_q;
  assign lk.phase_err = i_phase_err;
  assign lk.phase_valid = i_phase_valid;

  // Register writes
  always_comb begin
    high_th_d = high_th_q;
    low_th0_d = low_th0_q;
    low_th1_d = low_th1_q;
    low_sel_d = low_sel_q;
    meas_d = meas_q;
    hold_d = hold_q;
    gctrl_d = gctrl_q;
    tcfg_d = tcfg_q;
    pgain_d = pgain_q;
    igain_d = igain_q;
    sig_th_d = sig_th_q;
    mant_d = mant_q;
    exp_d = exp_q;
    if_ofs_d = if_ofs_q;
    if (i_wr_en) begin
      case (i_addr)
        rxgt_pkg::ADDR_HIGH_TH: high_th_d = i_wr_data[3:0];
        rxgt_pkg::ADDR_LOW_TH: begin
          low_th0_d = i_wr_data[3:0];
          low_th1_d = i_wr_data[rxgt_pkg::LOW_TH1_LSB +: 4];
        end
        rxgt_pkg::ADDR_LOW_SEL: low_sel_d = i_wr_data;
        rxgt_pkg::ADDR_MEAS: meas_d = i_wr_data[3:0];
        rxgt_pkg::ADDR_HOLD: hold_d = i_wr_data[5:0];
        rxgt_pkg::ADDR_GAIN_CTRL: gctrl_d = i_wr_data[1:0];
        rxgt_pkg::ADDR_TIM_CFG: tcfg_d = i_wr_data[1:0];
        rxgt_pkg::ADDR_PGAIN: pgain_d = i_wr_data & 8'h77;
        rxgt_pkg::ADDR_IGAIN: igain_d = i_wr_data;
        rxgt_pkg::ADDR_SIG_TH: sig_th_d = i_wr_data;
        rxgt_pkg::ADDR_CHANNEL_FILTER_WORD: begin
          mant_d = (i_wr_data[7:4] > rxgt_pkg::CHANNEL_FILTER_WORD_MANT_MAX) ? rxgt_pkg::CHANNEL_FILTER_WORD_MANT_MAX : i_wr_data[7:4];
          exp_d = (i_wr_data[3:0] > rxgt_pkg::CHANNEL_FILTER_WORD_EXP_MAX) ? rxgt_pkg::CHANNEL_FILTER_WORD_EXP_MAX : i_wr_data[3:0];
        end
        rxgt_pkg::ADDR_IF_OFS: if_ofs_d = i_wr_data;
        default: ;
      endcase
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads return zero
  always_comb begin
    rdata_d = 8'h00;
    if (i_rd_en) begin
      case (i_addr)
        rxgt_pkg::ADDR_HIGH_TH: rdata_d = {4'h0, high_th_q};
        rxgt_pkg::ADDR_LOW_TH: rdata_d = {low_th1_q, low_th0_q};
        rxgt_pkg::ADDR_LOW_SEL: rdata_d = low_sel_q;
        rxgt_pkg::ADDR_MEAS: rdata_d = {4'h0, meas_q};
        rxgt_pkg::ADDR_HOLD: rdata_d = {2'h0, hold_q};
        rxgt_pkg::ADDR_GAIN_CTRL: rdata_d = {6'h00, gctrl_q};
        rxgt_pkg::ADDR_TIM_CFG: rdata_d = {6'h00, tcfg_q};
        rxgt_pkg::ADDR_PGAIN: rdata_d = pgain_q;
        rxgt_pkg::ADDR_IGAIN: rdata_d = igain_q;
        rxgt_pkg::ADDR_SIG_TH: rdata_d = sig_th_q;
        rxgt_pkg::ADDR_CHANNEL_FILTER_WORD: rdata_d = {mant_q, exp_q};
        rxgt_pkg::ADDR_IF_OFS: rdata_d = if_ofs_q;
        rxgt_pkg::ADDR_STATUS: rdata_d = {2'h0, sync_q, lk.active, step_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      high_th_q <= rxgt_pkg::RST_HIGH_TH;
      low_th0_q <= rxgt_pkg::RST_LOW_TH0;
      low_th1_q <= rxgt_pkg::RST_LOW_TH1;
      low_sel_q <= rxgt_pkg::RST_LOW_SEL;
      meas_q <= rxgt_pkg::RST_MEAS;
      hold_q <= rxgt_pkg::RST_HOLD;
      gctrl_q <= rxgt_pkg::RST_GAIN_CTRL;
      tcfg_q <= rxgt_pkg::RST_TIM_CFG;
      pgain_q <= rxgt_pkg::RST_PGAIN;
      igain_q <= rxgt_pkg::RST_IGAIN;
      sig_th_q <= rxgt_pkg::RST_SIG_TH;
      mant_q <= rxgt_pkg::RST_CHANNEL_FILTER_WORD_MANT;
      exp_q <= rxgt_pkg::RST_CHANNEL_FILTER_WORD_EXP;
      if_ofs_q <= rxgt_pkg::RST_IF_OFS;
      rdata_q <= 8'h00;
    end else begin
      high_th_q <= high_th_d;
      low_th0_q <= low_th0_d;
      low_th1_q <= low_th1_d;
      low_sel_q <= low_sel_d;
      meas_q <= meas_d;
      hold_q <= hold_d;
      gctrl_q <= gctrl_d;
      tcfg_q <= tcfg_d;
      pgain_q <= pgain_d;
      igain_q <= igain_d;
      sig_th_q <= sig_th_d;
      mant_q <= mant_d;
      exp_q <= exp_d;
      if_ofs_q <= if_ofs_d;
      rdata_q <= rdata_d;
    end
  end

  // Gain loop
  always_comb begin
    gain_en = gctrl_q[rxgt_pkg::CTRL_EN_BIT];
    meas_len = rxgt_pkg::GAIN_UNIT_CYCLES << meas_q;
    hold_len = 19'(rxgt_pkg::GAIN_UNIT_CYCLES * 19'(hold_q));
    meas_load = meas_len - 19'h00001;
    hold_load = (hold_len == 19'h00000) ? 19'h00000 : hold_len - 19'h00001;
    frozen = gctrl_q[rxgt_pkg::CTRL_FREEZE_BIT] && sync_q;
    // A new reception clears the sync memory, but a sync in the same cycle wins
    sync_d = i_sync_det || (sync_q && !i_rx_start);
    st_d = st_q;
    step_d = step_q;
    cnt_d = cnt_q;
    all_low_d = all_low_q;
    if (!gain_en) begin
      // disabled loop parks at no attenuation
      st_d = rxgt_pkg::G_IDLE;
      step_d = 4'h0;
    end else if (!frozen) begin
      case (st_q)
        rxgt_pkg::G_IDLE: begin
          st_d = rxgt_pkg::G_MEAS;
          cnt_d = meas_load;
          all_low_d = 1'b1;
        end
        rxgt_pkg::G_HOLD: begin
          if (cnt_q == 19'h00000) begin
            st_d = rxgt_pkg::G_MEAS;
            cnt_d = meas_load;
            all_low_d = 1'b1;
          end else begin
            cnt_d = cnt_q - 19'h00001;
          end
        end
        rxgt_pkg::G_MEAS: begin
          if (lk.above_hi) begin
            // raise one step; no measure time when too loud
            if (step_q < rxgt_pkg::STEP_MAX) begin
              step_d = step_q + 4'h1;
            end
            st_d = rxgt_pkg::G_HOLD;
            cnt_d = hold_load;
          end else if (cnt_q == 19'h00000) begin
            // lower only after a whole interval under low threshold
            if (all_low_q && lk.below_lo && step_q != 4'h0) begin
              step_d = step_q - 4'h1;
              st_d = rxgt_pkg::G_HOLD;
              cnt_d = hold_load;
            end else begin
              cnt_d = meas_load;
              all_low_d = 1'b1;
            end
          end else begin
            cnt_d = cnt_q - 19'h00001;
            all_low_d = all_low_q && lk.below_lo;
          end
        end
        default: st_d = rxgt_pkg::G_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_q <= rxgt_pkg::G_IDLE;
      step_q <= 4'h0;
      cnt_q <= 19'h00000;
      all_low_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      st_q <= st_d;
      step_q <= step_d;
      cnt_q <= cnt_d;
      all_low_q <= all_low_d;
      sync_q <= sync_d;
    end
  end

  // each step is 6 dB of attenuation
  assign o_atten_step = step_q;
  // loop order; post-filter length to the demodulator
  assign o_timing_order = tcfg_q[rxgt_pkg::CFG_ORDER_BIT];
  assign o_postfilt_long = tcfg_q[rxgt_pkg::CFG_POSTF_BIT];
  assign o_timing_adj = lk.adj;
  assign o_timing_freq = lk.freq;
  assign o_timing_active = lk.active;
  assign o_channel_filter_word_mant = mant_q;
  assign o_channel_filter_word_exp = exp_q;
  assign o_if_offset = if_ofs_q;
  assign o_rd_data = rdata_q;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  a_step_max_bound: assert property (step_q <= rxgt_pkg::STEP_MAX)
    else $error("attenuation step above maximum");
  a_step_single_move: assert property ((step_q != $past(step_q)) |->
    (step_q == $past(step_q) + 4'h1 || step_q + 4'h1 == $past(step_q) || step_q == 4'h0))
    else $error("attenuation jumped by more than one step");
  a_high_raises_step: assert property ((gain_en && !frozen && st_q == rxgt_pkg::G_MEAS && lk.above_hi
    && step_q < rxgt_pkg::STEP_MAX) |=> (step_q == $past(step_q) + 4'h1 && st_q == rxgt_pkg::G_HOLD))
    else $error("high amplitude did not raise attenuation");
  a_lower_needs_low: assert property ((gain_en && step_q + 4'h1 == $past(step_q)) |->
    ($past(all_low_q) && $past(lk.below_lo) && $past(cnt_q) == 19'h00000))
    else $error("attenuation lowered without a full low interval");
  a_meas_load_len: assert property ((st_q == rxgt_pkg::G_HOLD && cnt_q == 19'h00000 && gain_en && !frozen)
    |=> (st_q == rxgt_pkg::G_MEAS && cnt_q == (rxgt_pkg::GAIN_UNIT_CYCLES << meas_q) - 19'h00001))
    else $error("measure interval loaded with wrong length");
  a_hold_after_move: assert property ((gain_en && step_q != $past(step_q)) |->
    (st_q == rxgt_pkg::G_HOLD && cnt_q == hold_load))
    else $error("no settle interval after attenuation change");
  // Disabling parks the step even in mid-settle, one cycle after the state still reads settle,
  // so the settle check only holds while the loop is enabled
  a_hold_no_change: assert property ((gain_en && st_q == rxgt_pkg::G_HOLD && cnt_q != 19'h00000)
    |=> $stable(step_q))
    else $error("attenuation changed during settle interval");
  a_disable_parks: assert property (!gain_en |=> step_q == 4'h0)
    else $error("disabled gain loop kept attenuation");
  a_freeze_holds: assert property ((gain_en && frozen) |=> (step_q == $past(step_q) || !gain_en))
    else $error("attenuation moved while frozen");
  a_timing_quiet: assert property ((!o_timing_active) |=> (o_timing_adj == 16'h0000))
    else $error("timing correction before signal threshold");
  a_gain_pair_sel: assert property (lk.kp_used == (sync_q ? lk.kp_slow : lk.kp_fast))
    else $error("wrong timing gain for sync state");
  a_channel_filter_word_range: assert property (mant_q <= rxgt_pkg::CHANNEL_FILTER_WORD_MANT_MAX && exp_q <= rxgt_pkg::CHANNEL_FILTER_WORD_EXP_MAX)
    else $error("channel filter word out of range");
  a_read_latency: assert property ((i_rd_en && i_addr == rxgt_pkg::ADDR_IF_OFS) |=> o_rd_data == $past(if_ofs_q))
    else $error("read data not returned one cycle later");

  c_raise_step: cover property (gain_en && step_q == $past(step_q) + 4'h1);
  c_lower_step: cover property (gain_en && step_q + 4'h1 == $past(step_q));
  c_frozen_hold: cover property (frozen && step_q != 4'h0);
  c_timing_second: cover property (o_timing_active && o_timing_order && i_phase_valid);
  c_settle_disabled: cover property (st_q == rxgt_pkg::G_HOLD && !gain_en);
endmodule : rxgt_top

// [rtl/rxgt_pkg.sv]
// Package with register map, reset values and timing constants of the rx gain/timing block
package rxgt_pkg;
  localparam logic [7:0] ADDR_HIGH_TH = 8'h00;
  localparam logic [7:0] ADDR_LOW_TH = 8'h01;
  localparam logic [7:0] ADDR_LOW_SEL = 8'h02;
  localparam logic [7:0] ADDR_MEAS = 8'h03;
  localparam logic [7:0] ADDR_HOLD = 8'h04;
  localparam logic [7:0] ADDR_GAIN_CTRL = 8'h05;
  localparam logic [7:0] ADDR_TIM_CFG = 8'h06;
  localparam logic [7:0] ADDR_PGAIN = 8'h07;
  localparam logic [7:0] ADDR_IGAIN = 8'h08;
  localparam logic [7:0] ADDR_SIG_TH = 8'h09;
  localparam logic [7:0] ADDR_CHANNEL_FILTER_WORD = 8'h0A;
  localparam logic [7:0] ADDR_IF_OFS = 8'h0B;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int LOW_TH1_LSB = 4;
  localparam int PGAIN_SLOW_LSB = 4;
  localparam int IGAIN_SLOW_LSB = 4;
  localparam int CHANNEL_FILTER_WORD_MANT_LSB = 4;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FREEZE_BIT = 1;
  localparam int CFG_ORDER_BIT = 0;
  localparam int CFG_POSTF_BIT = 1;
  localparam int STAT_ACTIVE_BIT = 4;
  localparam int STAT_SYNC_BIT = 5;
  localparam logic [3:0] RST_HIGH_TH = 4'h5;
  localparam logic [3:0] RST_LOW_TH0 = 4'h5;
  localparam logic [3:0] RST_LOW_TH1 = 4'h4;
  localparam logic [7:0] RST_LOW_SEL = 8'h10;
  localparam logic [3:0] RST_MEAS = 4'h2;
  localparam logic [5:0] RST_HOLD = 6'h0C;
  localparam logic [1:0] RST_GAIN_CTRL = 2'h1;
  localparam logic [1:0] RST_TIM_CFG = 2'h0;
  localparam logic [7:0] RST_PGAIN = 8'h21;
  localparam logic [7:0] RST_IGAIN = 8'h64;
  localparam logic [7:0] RST_SIG_TH = 8'h40;
  localparam logic [3:0] RST_CHANNEL_FILTER_WORD_MANT = 4'h0;
  localparam logic [3:0] RST_CHANNEL_FILTER_WORD_EXP = 4'h0;
  localparam logic [7:0] RST_IF_OFS = 8'h00;
  localparam logic [3:0] CHANNEL_FILTER_WORD_MANT_MAX = 4'h8;
  localparam logic [3:0] CHANNEL_FILTER_WORD_EXP_MAX = 4'h9;
  localparam int ATTEN_STEP_DB = 6;
  localparam int ATTEN_MAX_DB = 48;
  localparam logic [3:0] STEP_MAX = 4'(ATTEN_MAX_DB / ATTEN_STEP_DB);
  // Both gain-loop timers tick in units of this many digital clock cycles
  localparam logic [18:0] GAIN_UNIT_CYCLES = 19'h0000C;
  typedef enum logic [1:0] {G_IDLE, G_HOLD, G_MEAS} rxgt_gain_state_e;
endpackage : rxgt_pkg

// [rtl/rxgt_link_if.sv]
// Interface carrying threshold and timing-loop signals between the top and its helpers
`timescale 1ns/1ps
interface rxgt_link_if;
  logic [3:0] amp;
  logic [3:0] high_th;
  logic [3:0] low_th0;
  logic [3:0] low_th1;
  logic [7:0] low_sel;
  logic [3:0] step;
  logic above_hi;
  logic below_lo;
  logic order;
  logic [2:0] kp_fast;
  logic [2:0] kp_slow;
  logic [3:0] ki_fast;
  logic [3:0] ki_slow;
  logic [7:0] sig_th;
  logic [7:0] rssi;
  logic sync_seen;
  logic [7:0] phase_err;
  logic phase_valid;
  logic [15:0] adj;
  logic [15:0] freq;
  logic active;
  logic [2:0] kp_used;
  modport top (output amp, high_th, low_th0, low_th1, low_sel, step, order, kp_fast, kp_slow, ki_fast,
    ki_slow, sig_th, rssi, sync_seen, phase_err, phase_valid, input above_hi, below_lo, adj, freq, active,
    kp_used);
  modport eval (input amp, high_th, low_th0, low_th1, low_sel, step, output above_hi, below_lo);
  modport timing (input order, kp_fast, kp_slow, ki_fast, ki_slow, sig_th, rssi, sync_seen, phase_err,
    phase_valid, output adj, freq, active, kp_used);
endinterface : rxgt_link_if

// [rtl/rxgt_gain_eval.sv]
// Amplitude comparison against the high and the per-step low threshold
`timescale 1ns/1ps
module rxgt_gain_eval (
  rxgt_link_if.eval lk
);
  logic [2:0] sel_idx;
  logic [3:0] low_th;
  always_comb begin
    // Step 8 shares the select bit of step 7
    sel_idx = (lk.step > 4'h7) ? 3'h7 : lk.step[2:0];
    low_th = lk.low_sel[sel_idx] ? lk.low_th1 : lk.low_th0;
    lk.above_hi = lk.amp > lk.high_th;
    lk.below_lo = lk.amp < low_th;
  end
endmodule : rxgt_gain_eval

// [rtl/rxgt_timing_loop.sv]
// First or second order symbol timing loop with pre- and post-sync gains
`timescale 1ns/1ps
module rxgt_timing_loop (
  input wire logic i_clock,
  input wire logic i_rst_n,
  rxgt_link_if.timing lk
);
  logic active_q, active_d;
  logic signed [15:0] integ_q, integ_d;
  logic signed [15:0] adj_q, adj_d;
  logic signed [15:0] pe;
  logic [3:0] ki;
  always_comb begin
    lk.kp_used = lk.sync_seen ? lk.kp_slow : lk.kp_fast;
    ki = lk.sync_seen ? lk.ki_slow : lk.ki_fast;
    pe = 16'(signed'(lk.phase_err));
    active_d = lk.rssi > lk.sig_th;
    integ_d = integ_q;
    adj_d = 16'h0000;
    if (!active_q) begin
      integ_d = 16'h0000;
    end else if (lk.phase_valid) begin
      if (lk.order) begin
        integ_d = integ_q + (pe >>> ki);
        adj_d = (pe >>> lk.kp_used) + integ_d;
      end else begin
        // delay correction only; larger gain shifts more, so slower
        adj_d = pe >>> lk.kp_used;
      end
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      active_q <= 1'b0;
      integ_q <= 16'h0000;
      adj_q <= 16'h0000;
    end else begin
      active_q <= active_d;
      integ_q <= integ_d;
      adj_q <= adj_d;
    end
  end
  assign lk.adj = adj_q;
  assign lk.freq = integ_q;
  assign lk.active = active_q;
endmodule : rxgt_timing_loop

// [tb/rxgt_rf_model.sv]
// Behavioural model of the analog receive chain seen by the gain loop
`timescale 1ns/1ps
module rxgt_rf_model (
  input wire logic i_clock,
  input wire logic [3:0] i_atten_step,
  input wire logic [3:0] i_level,
  output logic [3:0] o_peak_amp
);
  // each step lowers the decimated peak by one unit
  always_ff @(posedge i_clock) begin
    o_peak_amp <= (i_level > i_atten_step) ? i_level - i_atten_step : 4'h0;
  end
endmodule : rxgt_rf_model

// [tb/rxgt_top_bench.sv]
// Self-checking bench for the receiver gain and timing recovery top
`timescale 1ns/1ps
module rxgt_top_bench;
  logic i_clock, i_rst_n, i_wr_en, i_rd_en, i_sync_det, i_rx_start, i_phase_valid;
  logic [7:0] i_addr, i_wr_data, i_rssi, i_phase_err, o_rd_data, o_if_offset;
  logic [3:0] i_peak_amp, o_atten_step, o_channel_filter_word_mant, o_channel_filter_word_exp, level, prev_step, hold_step;
  logic o_timing_order, o_postfilt_long, o_timing_active;
  logic [15:0] o_timing_adj, o_timing_freq, integ, sx;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int last_chg = 0;
  logic [31:0] seed = 32'h860CB1A7;
  logic [7:0] rd_q[$];
  logic [32:0] adj_q[$];
  logic [32:0] adj_e;
  logic rd_taken = 1'b0, pv_taken = 1'b0, gain_mon = 1'b0;

  rxgt_top u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_peak_amp(i_peak_amp), .i_rssi(i_rssi),
    .i_sync_det(i_sync_det), .i_rx_start(i_rx_start), .i_phase_err(i_phase_err),
    .i_phase_valid(i_phase_valid), .o_atten_step(o_atten_step), .o_timing_order(o_timing_order),
    .o_postfilt_long(o_postfilt_long), .o_timing_adj(o_timing_adj), .o_timing_freq(o_timing_freq),
    .o_timing_active(o_timing_active), .o_channel_filter_word_mant(o_channel_filter_word_mant), .o_channel_filter_word_exp(o_channel_filter_word_exp),
    .o_if_offset(o_if_offset));
  rxgt_rf_model u_rf (.i_clock(i_clock), .i_atten_step(o_atten_step), .i_level(level), .o_peak_amp(i_peak_amp));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [15:0] sh(input logic [7:0] p, input int k);
    logic signed [15:0] v;
    v = {{8{p[7]}}, p};
    return v >>> k;
  endfunction : sh

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_clock);
    i_wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd_en <= 1'b1;
    rd_q.push_back(e);
    @(posedge i_clock);
    i_rd_en <= 1'b0;
  endtask : rd

  task automatic ph(input logic [7:0] pe, input logic [32:0] e);
    @(posedge i_clock);
    i_phase_err <= pe;
    i_phase_valid <= 1'b1;
    adj_q.push_back(e);
    @(posedge i_clock);
    i_phase_valid <= 1'b0;
  endtask : ph

  task automatic pulse(input bit rx);
    @(posedge i_clock);
    if (rx) i_rx_start <= 1'b1; else i_sync_det <= 1'b1;
    @(posedge i_clock);
    i_rx_start <= 1'b0;
    i_sync_det <= 1'b0;
  endtask : pulse

  task automatic wait_step(input logic [3:0] s, input int cycles);
    int n;
    n = 0;
    while (o_atten_step !== s && n < cycles) begin
      @(negedge i_clock);
      n++;
    end
    repeat (40) @(negedge i_clock);
    check(16'(o_atten_step), 16'(s));
  endtask : wait_step

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // Cycle count and hang guard, sized for the whole sequence
  always @(posedge i_clock) begin
    rd_taken <= i_rd_en;
    pv_taken <= i_phase_valid;
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      num_errors++;
      final_report();
    end
  end

  always @(negedge i_clock) begin
    if (rd_taken) check(16'(o_rd_data), 16'(rd_q.pop_front()));
    if (pv_taken) begin
      adj_e = adj_q.pop_front();
      check(o_timing_adj, adj_e[31:16]);
      if (adj_e[32]) check(o_timing_freq, adj_e[15:0]);
    end
    if (gain_mon && o_atten_step !== prev_step) begin
      check(16'(o_atten_step > prev_step ? o_atten_step - prev_step : prev_step - o_atten_step), 16'h0001);
      check(16'(cyc - last_chg >= (o_atten_step < prev_step ? 24 : 12)), 16'h0001);
      check(16'(o_atten_step <= 4'h8), 16'h0001);
      last_chg = cyc;
    end
    prev_step = o_atten_step;
  end

  initial begin
    {i_rst_n, i_wr_en, i_rd_en, i_sync_det, i_rx_start, i_phase_valid} = '0;
    {i_addr, i_wr_data, i_rssi, i_phase_err} = '0;
    level = 4'h0;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd(rxgt_pkg::ADDR_HIGH_TH, {4'h0, rxgt_pkg::RST_HIGH_TH});
    rd(rxgt_pkg::ADDR_LOW_TH, {rxgt_pkg::RST_LOW_TH1, rxgt_pkg::RST_LOW_TH0});
    rd(rxgt_pkg::ADDR_LOW_SEL, rxgt_pkg::RST_LOW_SEL);
    rd(rxgt_pkg::ADDR_MEAS, {4'h0, rxgt_pkg::RST_MEAS});
    rd(rxgt_pkg::ADDR_HOLD, {2'h0, rxgt_pkg::RST_HOLD});
    rd(8'h20, 8'h00);
    wr(rxgt_pkg::ADDR_CHANNEL_FILTER_WORD, 8'hFF);
    rd(rxgt_pkg::ADDR_CHANNEL_FILTER_WORD, 8'h89);
    check({8'h00, o_channel_filter_word_mant, o_channel_filter_word_exp}, 16'h0089);
    seed = lfsr(seed);
    wr(rxgt_pkg::ADDR_IF_OFS, seed[7:0]);
    rd(rxgt_pkg::ADDR_IF_OFS, seed[7:0]);
    check(16'(o_if_offset), 16'(seed[7:0]));
    for (int i = 0; i < 4; i++) begin
      wr(rxgt_pkg::ADDR_TIM_CFG, 8'(i));
      @(negedge i_clock);
      check(16'({o_postfilt_long, o_timing_order}), 16'(i));
    end
    // Short timers give a raise about every dozen cycles and a lowering about every two dozen
    wr(rxgt_pkg::ADDR_GAIN_CTRL, 8'h00);
    wr(rxgt_pkg::ADDR_MEAS, 8'h00);
    wr(rxgt_pkg::ADDR_HOLD, 8'h01);
    last_chg = cyc - 100;
    gain_mon = 1'b1;
    level <= 4'hF;
    wr(rxgt_pkg::ADDR_GAIN_CTRL, 8'h01);
    wait_step(4'h8, 400);
    level = 4'h0;
    wait_step(4'h0, 600);
    level = 4'hA;
    wait_step(4'h5, 400);
    // Step 4 takes the lower threshold, so the loop must settle there
    level = 4'h8;
    wait_step(4'h4, 400);
    gain_mon = 1'b0;
    level = 4'h0;
    wr(rxgt_pkg::ADDR_GAIN_CTRL, 8'h03);
    level <= 4'hF;
    repeat (30) @(posedge i_clock);
    pulse(1'b0);
    repeat (3) @(negedge i_clock);
    hold_step = o_atten_step;
    repeat (100) @(negedge i_clock);
    check(16'(o_atten_step), 16'(hold_step));
    pulse(1'b1);
    wr(rxgt_pkg::ADDR_GAIN_CTRL, 8'h00);
    repeat (2) @(negedge i_clock);
    check(16'(o_atten_step), 16'h0000);
    // Back to first order; the mode loop above left order and post-filter set
    wr(rxgt_pkg::ADDR_TIM_CFG, 8'h00);
    i_rssi <= 8'h30;
    repeat (3) @(posedge i_clock);
    check(16'(o_timing_active), 16'h0000);
    ph(8'h40, 33'h0);
    i_rssi <= 8'h80;
    repeat (3) @(posedge i_clock);
    rd(rxgt_pkg::ADDR_STATUS, 8'h10);
    for (int k = 0; k < 8; k++) begin
      wr(rxgt_pkg::ADDR_PGAIN, {1'b0, 3'(7 - k), 1'b0, 3'(k)});
      seed = lfsr(seed);
      ph(seed[7:0], {1'b0, sh(seed[7:0], k), 16'h0});
    end
    pulse(1'b0);
    seed = lfsr(seed);
    ph(seed[7:0], {1'b0, sh(seed[7:0], 0), 16'h0});
    pulse(1'b1);
    wr(rxgt_pkg::ADDR_TIM_CFG, 8'h01);
    wr(rxgt_pkg::ADDR_IGAIN, 8'h32);
    wr(rxgt_pkg::ADDR_PGAIN, 8'h51);
    i_rssi <= 8'h30;
    repeat (3) @(posedge i_clock);
    i_rssi <= 8'h80;
    repeat (3) @(posedge i_clock);
    check(16'(o_timing_active), 16'h0001);
    integ = 16'h0;
    repeat (3) begin
      seed = lfsr(seed);
      sx = sh(seed[7:0], 2);
      integ = integ + sx;
      ph(seed[7:0], {1'b1, sh(seed[7:0], 1) + integ, integ});
    end
    repeat (3) @(posedge i_clock);
    final_report();
  end
endmodule : rxgt_top_bench
